// [core/multiphase_interleaved_pwm_timing.sv]
// Top of the interleaved phase timing core: timebase, phase detect, averaging.
`timescale 1ns/100ps
module multiphase_interleaved_pwm_timing #(
    parameter int CYCLE_LEN = pwm_timing_pkg::CYCLE_TICKS
) (
    input  wire logic                                       mclk,
    input  wire logic                                       reset,
    input  wire logic [2:0][pwm_timing_pkg::SENSE_W-1:0]    channel_current_sense_in,
    input  wire logic [2:0]                                 comp_trip_in,
    input  wire logic                                       phase_three_drive_in,
    output logic                                            phase_one_drive_out,
    output logic                                            phase_two_drive_out,
    output logic                                            phase_three_drive_out,
    output logic                                            phase_three_drive_oe,
    output logic                                            two_phase_mode,
    output logic                                            cycle_start,
    output logic [2:0][pwm_timing_pkg::SENSE_W+1:0]         balance_error,
    output logic [pwm_timing_pkg::SENSE_W-1:0]              avg_current,
    output logic                                            overcurrent
);
    import pwm_timing_pkg::*;

    // Cycle counter geometry
    localparam int            CW        = $clog2(CYCLE_LEN);
    localparam logic [CW-1:0] HALF_PT   = CW'(CYCLE_LEN / 2);
    localparam logic [CW-1:0] THIRD_PT  = CW'(CYCLE_LEN / 3);
    localparam logic [CW-1:0] TWO3_PT   = CW'((2 * CYCLE_LEN) / 3);
    localparam logic [CW-1:0] LAST_PT   = CW'(CYCLE_LEN - 1);
    localparam logic [7:0]    DIV_LAST  = 8'(TICK_DIV - 1);
    localparam logic [4:0]    DET_LAST  = 5'(DETECT_CLKS - 1);

    // Spacing of terminations in master clocks, for the checks below
    localparam int HALF_CLKS  = (CYCLE_LEN / 2) * TICK_DIV;
    localparam int THIRD_CLKS = (CYCLE_LEN / 3) * TICK_DIV;

    logic [7:0]           div_ff;        // Timebase divider
    logic                 tick_ff;       // One-cycle timebase enable
    logic [CW-1:0]        cyc_ff;        // Position within the switching cycle
    mode_state_type       state_ff;      // Phase detect then run
    mode_state_type       nxt_state;
    logic [4:0]           det_ff;        // Wait before reading the strap
    logic                 two_phase_ff;  // Latched phase count
    logic                 p3_meta_ff;    // Strap synchroniser, first stage
    logic                 p3_sync_ff;    // Strap synchroniser, second stage
    logic                 run;
    logic [2:0]           term;          // Termination command per channel
    logic [2:0]           active;        // Channel in use
    logic [2:0]           trip_meta_ff;  // Comparator trip, first stage
    logic [2:0]           trip_sync_ff;  // Comparator trip, second stage
    logic [2:0][SENSE_W-1:0] sense_meta_ff;  // Current data, first stage
    logic [2:0][SENSE_W-1:0] sense_sync_ff;  // Current data, second stage
    logic [2:0][SENSE_W-1:0] sample;     // Held per-channel samples
    logic [2:0]           drive;         // Per-channel drive levels
    logic [SENSE_W+1:0]   sum_all;       // Sum of active samples
    logic [SENSE_W-1:0]   nxt_avg;
    logic [SENSE_W-1:0]   avg_ff;        // Average channel current
    logic                 avg_stb_ff;    // Average just refreshed
    logic                 oc_ff;         // Average above the limit
    logic                 start_ff;      // Registered cycle start pulse

    // Timebase divider: every slower rate is this one-cycle enable
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_LAST) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // Strap synchroniser; only the second stage is read
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            p3_meta_ff <= 1'b0;
            p3_sync_ff <= 1'b0;
        end else begin
            p3_meta_ff <= phase_three_drive_in;
            p3_sync_ff <= p3_meta_ff;
        end
    end

    // Detect sequence: pin released, wait for it to settle, latch, run
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_WAIT: begin
                if (det_ff == DET_LAST) begin
                    nxt_state = ST_LATCH;
                end
            end
            ST_LATCH: begin
                nxt_state = ST_RUN;
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_WAIT;    // Illegal code restarts detection
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_WAIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Settling counter for the strap read
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            det_ff <= '0;
        end else if (state_ff == ST_WAIT) begin
            det_ff <= det_ff + 5'h01;
        end
    end

    // Phase count: three by default, two if the third pin reads high
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            two_phase_ff <= 1'b0;                 // R01
        end else if (state_ff == ST_LATCH) begin
            two_phase_ff <= p3_sync_ff;           // R02
        end
    end

    assign run = (state_ff == ST_RUN);

    // Cycle counter on the timebase; one wrap is one switching cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cyc_ff <= '0;
        end else if (run && tick_ff) begin
            cyc_ff <= (cyc_ff == LAST_PT) ? '0 : cyc_ff + CW'(1);   // R15
        end
    end

    // Termination commands derived from the counter position
    assign term[0] = run && tick_ff && (cyc_ff == '0);                          // R03
    assign term[1] = run && tick_ff && (cyc_ff == (two_phase_ff ? HALF_PT : THIRD_PT)); // R04 R05
    assign term[2] = run && tick_ff && !two_phase_ff && (cyc_ff == TWO3_PT);    // R05
    assign active  = {run && !two_phase_ff, run, run};                          // R11

    // Two-stage synchronisers for the comparator trips and current data
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trip_meta_ff  <= '0;
            trip_sync_ff  <= '0;
            sense_meta_ff <= '0;
            sense_sync_ff <= '0;
        end else begin
            trip_meta_ff  <= comp_trip_in;
            trip_sync_ff  <= trip_meta_ff;
            sense_meta_ff <= channel_current_sense_in;
            sense_sync_ff <= sense_meta_ff;
        end
    end

    // Identical channel slices
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            chan_ctl_type ctl;
            logic signed [SENSE_W+1:0] trim;
            assign ctl.terminate = term[gi];
            assign ctl.active    = active[gi];
            pwm_phase_channel #(
                .CYCLE_LEN (CYCLE_LEN)
            ) u_chan (
                .mclk    (mclk),
                .reset   (reset),
                .tick    (tick_ff),
                .ctl     (ctl),
                .trip    (trip_sync_ff[gi]),
                .sense   (sense_sync_ff[gi]),
                .avg     (avg_ff),
                .avg_stb (avg_stb_ff),
                .drive   (drive[gi]),
                .sample  (sample[gi]),
                .trim    (trim)
            );
            assign balance_error[gi] = trim;
        end
    endgenerate

    // Average of the active samples; unused third sample is left out
    assign sum_all = {2'b00, sample[0]} + {2'b00, sample[1]}
                   + (two_phase_ff ? '0 : {2'b00, sample[2]});
    assign nxt_avg = two_phase_ff ? SENSE_W'(sum_all >> 1)
                                  : SENSE_W'(sum_all / (SENSE_W + 2)'(3));   // R12

    // Refresh at the end of the cycle, after every channel has sampled
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avg_ff     <= '0;
            avg_stb_ff <= 1'b0;
        end else begin
            avg_stb_ff <= run && tick_ff && (cyc_ff == LAST_PT);
            if (run && tick_ff && (cyc_ff == LAST_PT)) begin
                avg_ff <= nxt_avg;            // R10
            end
        end
    end

    // Overcurrent compare on the average; shutdown policy lives elsewhere
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            oc_ff <= 1'b0;
        end else begin
            oc_ff <= avg_ff > OC_LIMIT_RST;   // R10
        end
    end

    // Cycle start marker for downstream counters
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= term[0];
        end
    end

    // Pin three is only driven in three-phase run, so the strap stays readable
    assign phase_one_drive_out   = drive[0];
    assign phase_two_drive_out   = drive[1];
    assign phase_three_drive_out = drive[2];
    assign phase_three_drive_oe  = run && !two_phase_ff;   // R02
    assign two_phase_mode        = two_phase_ff;
    assign cycle_start           = start_ff;
    assign avg_current           = avg_ff;                 // R10
    assign overcurrent           = oc_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_ch1_term_low: assert property (term[0] |=> !phase_one_drive_out) // R03
        else $error("channel one stayed high after termination");
    a_half_spacing: assert property (term[0] && two_phase_ff |-> ##HALF_CLKS term[1]) // R04
        else $error("channel two not half a cycle after channel one");
    a_third_spacing: assert property (term[0] && !two_phase_ff |-> ##THIRD_CLKS term[1]) // R05
        else $error("channel two not a third of a cycle after channel one");
    a_third_chain: assert property (term[1] && !two_phase_ff |-> ##THIRD_CLKS term[2]) // R05
        else $error("channel three not a third of a cycle after channel two");
    a_default_three: assert property (run && !two_phase_ff |-> phase_three_drive_oe) // R01
        else $error("three-phase run without driving pin three");
    a_two_phase_idle: assert property (two_phase_ff |-> !phase_three_drive_oe && !drive[2]) // R02
        else $error("pin three driven in two-phase timing");
    a_strap_latch: assert property (state_ff == ST_LATCH |=> two_phase_ff == $past(p3_sync_ff)) // R02
        else $error("phase count not taken from the strap");
    a_avg_refresh: assert property (avg_stb_ff |-> avg_ff == $past(nxt_avg)) // R12
        else $error("average not refreshed from active samples");

    c_two_phase_cycle: cover property (two_phase_ff && term[1]);
    c_three_phase_cycle: cover property (!two_phase_ff && term[2]);
    c_ch1_rise: cover property ($rose(phase_one_drive_out));
    c_overcurrent: cover property ($rose(oc_ff));
endmodule

// [core/pwm_timing_pkg.sv]
// Shared constants and carrier types for the interleaved phase timing core.
// Behaviour
// (R01) Three-phase timing unless a strap says otherwise
// (R02) Third drive strapped high selects two-phase timing
// (R03) Channel-1 termination starts each switching cycle
// (R04) Two-phase: channel 2 terminates half cycle later
// (R05) Three-phase: terminations spaced one third cycle apart
// (R06) Output held low quarter cycle after termination
// (R07) Re-enabled output rises on ramp crossing
// (R08) High output stays high until next termination
// (R09) One settled current sample per cycle, low-side
// (R10) Sample feeds balance, load line, overcurrent
// (R11) Unused channel sampling stays inactive
// (R12) Balance error is sample minus active average
// (R13) Filtered balance error trims commanded pulse width
// (R14) Comparator trip sampled on timebase, used when enabled
// (R15) Offsets and off time from divided cycle counter
package pwm_timing_pkg;

    // Master clock period and the switching period in nanoseconds
    localparam int CLK_PERIOD_NS = 8;
    localparam int SW_PERIOD_NS  = 3840;

    // Timebase ticks per switching cycle; divisible by 2, 3 and 4
    localparam int CYCLE_TICKS = 96;

    // Master clocks per timebase tick, derived from the two periods
    localparam int TICK_DIV = SW_PERIOD_NS / (CLK_PERIOD_NS * CYCLE_TICKS);

    // Ticks of settling after termination before the current sample
    localparam int SETTLE_TICKS = 8;

    // Master clocks the third drive pin is left undriven after reset
    localparam int DETECT_CLKS = 16;

    // Width of one digitised channel current
    localparam int SENSE_W = 8;

    // Balance filter: each cycle moves one eighth toward the new error
    localparam int FILT_SHIFT = 3;

    // Average current above which overcurrent is flagged
    localparam logic [SENSE_W-1:0] OC_LIMIT_RST = 8'hc0;

    // Reset level of every drive output
    localparam logic DRIVE_RST = 1'b0;

    // Phase count detection and run states
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_LATCH = 2'b01,
        ST_RUN   = 2'b11
    } mode_state_type;

    // Per-channel timing commands from the cycle counter
    typedef struct packed {
        logic terminate;
        logic active;
    } chan_ctl_type;

endpackage

// [core/pwm_phase_channel.sv]
// One phase channel: off timer, drive latch, current sampler, balance filter.
`timescale 1ns/100ps
module pwm_phase_channel #(
    parameter int CYCLE_LEN = pwm_timing_pkg::CYCLE_TICKS
) (
    input  wire logic                                 mclk,
    input  wire logic                                 reset,
    input  wire logic                                 tick,
    input  pwm_timing_pkg::chan_ctl_type              ctl,
    input  wire logic                                 trip,
    input  wire logic [pwm_timing_pkg::SENSE_W-1:0]   sense,
    input  wire logic [pwm_timing_pkg::SENSE_W-1:0]   avg,
    input  wire logic                                 avg_stb,
    output logic                                      drive,
    output logic [pwm_timing_pkg::SENSE_W-1:0]        sample,
    output logic signed [pwm_timing_pkg::SENSE_W+1:0] trim
);
    import pwm_timing_pkg::*;

    localparam int             CW           = $clog2(CYCLE_LEN);
    localparam logic [CW-1:0]  QUARTER      = CW'(CYCLE_LEN / 4);
    localparam logic [CW-1:0]  SETTLE       = CW'(SETTLE_TICKS);
    localparam int             QUARTER_CLKS = (CYCLE_LEN / 4) * TICK_DIV;

    logic                       armed_ff;    // A termination has been seen
    logic [CW-1:0]              off_ff;      // Ticks spent in forced off time
    logic                       en_ff;       // Forced off time is over
    logic                       drive_ff;    // Drive output level
    logic [CW-1:0]              since_ff;    // Ticks since termination
    logic                       sampled_ff;  // Sample already taken this cycle
    logic [SENSE_W-1:0]         sample_ff;   // Held current sample
    logic signed [SENSE_W+1:0]  acc_ff;      // Filtered balance error
    logic                       sample_stb;  // Take the sample now
    logic signed [SENSE_W+1:0]  balance_error;
    logic signed [SENSE_W+3:0]  step;

    // Arm after the first termination so nothing switches before timing runs
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            armed_ff <= 1'b0;
        end else if (ctl.terminate) begin
            armed_ff <= 1'b1;
        end
    end

    // Forced off timer restarts on every termination
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            off_ff <= '0;
            en_ff  <= 1'b0;
        end else if (ctl.terminate) begin
            off_ff <= '0;          // R06
            en_ff  <= 1'b0;        // R06
        end else if (tick && armed_ff && ctl.active && !en_ff) begin
            off_ff <= off_ff + CW'(1);          // R15
            if (off_ff == QUARTER - CW'(1)) begin
                en_ff <= 1'b1;     // R06
            end
        end
    end

    // Drive latch: termination clears, trip sets once enabled
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            drive_ff <= DRIVE_RST;
        end else if (ctl.terminate || !ctl.active) begin
            drive_ff <= 1'b0;      // R03 R08
        end else if (tick && en_ff && trip) begin
            drive_ff <= 1'b1;      // R07 R14
        end
    end

    // Sample once, a settling interval into the low-side conduction
    assign sample_stb = tick && armed_ff && ctl.active && !sampled_ff && (since_ff == SETTLE);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            since_ff   <= '0;
            sampled_ff <= 1'b0;
        end else if (ctl.terminate) begin
            since_ff   <= '0;
            sampled_ff <= 1'b0;
        end else if (sample_stb) begin
            sampled_ff <= 1'b1;    // R09
        end else if (tick && armed_ff && ctl.active && !sampled_ff) begin
            since_ff <= since_ff + CW'(1);
        end
    end

    // Held sample; an idle channel never loads it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sample_ff <= '0;
        end else if (!ctl.active) begin
            sample_ff <= '0;       // R11
        end else if (sample_stb) begin
            sample_ff <= sense;    // R09 R10
        end
    end

    // Balance error against the average of the active channels
    assign balance_error = $signed({2'b00, sample_ff}) - $signed({2'b00, avg});   // R12
    assign step = (SENSE_W + 4)'(balance_error) - (SENSE_W + 4)'(acc_ff);

    // First-order filter; small steps keep the trim from chasing ripple
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            acc_ff <= '0;
        end else if (!ctl.active) begin
            acc_ff <= '0;
        end else if (avg_stb) begin
            acc_ff <= acc_ff + (SENSE_W + 2)'(step >>> FILT_SHIFT);   // R13
        end
    end

    assign drive  = drive_ff;
    assign sample = sample_ff;
    assign trim   = acc_ff;

    // Helper: master clocks the drive has been low, saturating
    logic [7:0] low_clk_ff;
    logic [1:0] samp_cnt_ff;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            low_clk_ff <= '0;
        end else if (drive_ff) begin
            low_clk_ff <= '0;
        end else if (low_clk_ff != 8'hff) begin
            low_clk_ff <= low_clk_ff + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            samp_cnt_ff <= '0;
        end else if (ctl.terminate) begin
            samp_cnt_ff <= '0;
        end else if (sample_stb && samp_cnt_ff != 2'h3) begin
            samp_cnt_ff <= samp_cnt_ff + 2'h1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_off_time_held: assert property ($rose(drive_ff) |-> low_clk_ff >= 8'(QUARTER_CLKS)) // R06
        else $error("drive rose before the forced off time ended");
    a_rise_needs_trip: assert property ($rose(drive_ff) |-> $past(trip) && $past(tick)) // R07
        else $error("drive rose without a sampled comparator trip");
    a_high_until_term: assert property (drive_ff && !ctl.terminate && ctl.active |=> drive_ff) // R08
        else $error("drive fell without a termination");
    a_one_sample_cycle: assert property (sample_stb |-> samp_cnt_ff == 2'h0) // R09
        else $error("second current sample in one cycle");
    a_idle_channel_quiet: assert property (!ctl.active |=> !drive_ff && sample_ff == '0) // R11
        else $error("unused channel is switching or sampling");
    a_trim_follows: assert property (avg_stb && ctl.active |=> acc_ff != $past(acc_ff) || $past(step >>> FILT_SHIFT) == 0) // R13
        else $error("balance filter did not move toward the error");
endmodule

// [test/gate_driver_model.sv]
// Behavioural model of the external gate drivers that face the drive outputs.
`timescale 1ns/100ps
module gate_driver_model (
    input  wire logic             mclk,
    input  wire logic [2:0]       drive,
    input  wire logic             drive_three_oe,
    input  wire logic             strap_to_supply,
    output logic                  pin_three,
    output logic [2:0][15:0]      on_count
);
    // Last sampled drive levels, used to count upper-switch turn-ons
    logic [2:0]       last_ff  = 3'b000;

    // Strap to the supply wins over everything, as a hard tie would;
    // an unstrapped, undriven pin rests low at the driver's input pull-down
    assign pin_three = strap_to_supply ? 1'b1 : (drive_three_oe ? drive[2] : 1'b0);

    // Count rising edges per phase: each one turns an upper switch on;
    // a plain process, since the count is also cleared at time zero
    initial on_count = '0;
    always @(posedge mclk) begin
        last_ff <= drive;
        for (int i = 0; i < 3; i++) begin
            if (drive[i] === 1'b1 && last_ff[i] === 1'b0) begin
                on_count[i] <= on_count[i] + 16'h0001;
            end
        end
    end
endmodule

// [test/tb.sv]
// Self-checking testbench for the interleaved phase timing core.
`timescale 1ns/100ps
module tb;
    import pwm_timing_pkg::*;
    logic                    mclk;
    logic                    reset;
    logic [2:0][SENSE_W-1:0] sense;
    logic [2:0]              trip;
    logic                    strap;
    logic                    pin_three;
    logic [2:0]              drv;
    logic                    p3_oe;
    logic                    two_ph;
    logic                    cyc_st;
    logic                    oc;
    logic [2:0][SENSE_W+1:0] berr;
    logic [SENSE_W-1:0]      avg;
    logic [2:0][15:0]        on_cnt;
    int                      n_mismatch = 0;
    int                      comparisons = 0;

    // Free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    multiphase_interleaved_pwm_timing dut_u (.mclk(mclk), .reset(reset),
        .channel_current_sense_in(sense), .comp_trip_in(trip),
        .phase_three_drive_in(pin_three), .phase_one_drive_out(drv[0]),
        .phase_two_drive_out(drv[1]), .phase_three_drive_out(drv[2]),
        .phase_three_drive_oe(p3_oe), .two_phase_mode(two_ph), .cycle_start(cyc_st),
        .balance_error(berr), .avg_current(avg), .overcurrent(oc));

    gate_driver_model drivers_u (.mclk(mclk), .drive(drv), .drive_three_oe(p3_oe),
        .strap_to_supply(strap), .pin_three(pin_three), .on_count(on_cnt));

    // Closing report; the only place the run ends
    task automatic test_done();
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Four-state value compare
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Measured clock count against an allowed window
    task automatic check_in(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Advance one clock and sample after the edge has settled
    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    // A bound that runs out is a hang: count it and stop
    task automatic bound(input int n);
        if (n >= 1000) begin
            n_mismatch++;
            test_done();
        end
    endtask

    // Strap must be in place while reset is held, so it is set with it
    task automatic do_reset(input logic tied);
        @(posedge mclk);
        reset <= 1'b1;
        strap <= tied;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (30) step();
    endtask

    // Always steps first, so back-to-back calls find distinct cycles
    task automatic sync_start();
        int n;
        n = 0;
        do begin
            step();
            n++;
        end while (cyc_st !== 1'b1 && n < 1000);
        bound(n);
    endtask

    // Clocks until the channel is next high, then optionally low again
    task automatic time_edge(input int ch, input bit to_low, output int n);
        n = 0;
        while (drv[ch] !== 1'b1 && n < 1000) begin step(); n++; end
        while (to_low && drv[ch] !== 1'b0 && n < 1000) begin step(); n++; end
        bound(n);
    endtask

    // Default strap: three phases spaced a third, off time, rise on trip
    task automatic test_three_phase();
        int n;
        int m;
        logic [15:0] c;
        @(posedge mclk);
        trip  <= 3'b111;
        sense <= {8'h90, 8'h60, 8'h30};
        do_reset(1'b0);
        check_eq(two_ph, 1'b0);
        check_eq(p3_oe, 1'b1);
        repeat (2) sync_start();
        time_edge(1, 1'b1, n);
        check_in(n, 160, 160);
        sync_start();
        time_edge(2, 1'b1, n);
        check_in(n, 320, 320);
        sync_start();
        time_edge(0, 1'b0, n);
        check_in(n, 120, 126);
        time_edge(0, 1'b1, m);
        check_in(n + m, 480, 480);
        check_eq(avg, 8'h60);
        check_eq(oc, 1'b0);
        check_eq(berr[1], 10'h000);
        check_eq(berr[0][9], 1'b1);
        check_eq({berr[2][9], berr[2] == 10'h000}, 2'b00);
        @(posedge mclk);
        trip <= 3'b110;
        repeat (2) sync_start();
        c = on_cnt[0];
        sync_start();
        check_eq(on_cnt[0], c);
        $display("test_three_phase done");
    endtask

    // Average above the limit flags overcurrent; equal to it does not
    task automatic test_overcurrent();
        @(posedge mclk);
        sense <= {3{8'hd0}};
        repeat (3) sync_start();
        check_eq(avg, 8'hd0);
        check_eq(oc, 1'b1);
        @(posedge mclk);
        sense <= {3{8'hc0}};
        repeat (3) sync_start();
        check_eq(oc, 1'b0);
        $display("test_overcurrent done");
    endtask

    // Pin three tied high: half-cycle spacing, third channel idle
    task automatic test_two_phase();
        int n;
        logic [15:0] c;
        c = on_cnt[2];
        @(posedge mclk);
        trip  <= 3'b111;
        sense <= {8'h70, 8'h50, 8'h10};
        do_reset(1'b1);
        check_eq(two_ph, 1'b1);
        check_eq(p3_oe, 1'b0);
        repeat (3) sync_start();
        time_edge(1, 1'b1, n);
        check_in(n, 240, 240);
        repeat (2) sync_start();
        check_eq(avg, 8'h30);
        check_eq(berr[2], 10'h000);
        check_eq({berr[0][9], berr[1][9]}, 2'b10);
        check_eq(on_cnt[2], c);
        check_eq(drv[2], 1'b0);
        $display("test_two_phase done");
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        strap = 1'b0;
        trip  = 3'b000;
        sense = '0;
        test_three_phase();
        test_overcurrent();
        test_two_phase();
        test_done();
    end
endmodule
